// [logic/pmtx_csrs.sv]
`timescale 1ns/10ps
module pmtx_csrs #(
	parameter int         FLASH_ACCESS_NS = 120,
	parameter logic       SUPPORT_D1      = 1'b0,
	parameter logic       SUPPORT_D2      = 1'b0,
	parameter int         ADDR_W          = 8
) (
	// APB slave
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Power management
	input  wire logic              wake_event,
	output logic      [1:0]        power_state,
	output logic                   pme_out,
	output logic                   pme_oe,
	// Transmit events from the MAC
	input  wire logic              link_speed_100,
	input  wire logic              tx_burst_ok,
	input  wire logic              tx_burst_fail,
	input  wire logic              tx_start,
	output logic                   tx_done_irq,
	output logic                   tx_idle_irq,
	// Serial EEPROM loader
	input  wire logic              ee_load,
	input  wire logic [47:0]       ee_station_addr,
	// Flash boot ROM pins
	output logic      [16:0]       flash_addr,
	output logic                   flash_ce_n,
	output logic                   flash_oe_n,
	output logic                   flash_we_n,
	input  wire logic [7:0]        flash_dq_in,
	output logic      [7:0]        flash_dq_out,
	output logic                   flash_dq_oe,
	// Shared LED / address pin
	input  wire logic              led_fd_col,
	output logic                   shared_led_pin
);

	localparam int FL_RD_CYC =
		(FLASH_ACCESS_NS + pmtx_pkg::CLK_PERIOD_NS - 1) / pmtx_pkg::CLK_PERIOD_NS
		+ pmtx_pkg::SYNC_STAGES;
	localparam int FL_WR_CYC =
		(FLASH_ACCESS_NS + pmtx_pkg::CLK_PERIOD_NS - 1) / pmtx_pkg::CLK_PERIOD_NS;

	// Register state
	logic                            wake_signal_enable;
	logic                            wake_event_flag;
	pmtx_pkg::pmtx_pstate_t          power_state_field;
	logic [pmtx_pkg::TXBR_CNT_W-1:0] tx_burst_count;
	logic [pmtx_pkg::TXBR_TO_W-1:0]  tx_idle_timeout;
	logic                            rom_addr16_pin_select;
	logic                            rom_rd_req;
	logic                            rom_wr_req;
	logic [pmtx_pkg::ROM_ADDR_W-1:0] rom_addr;
	logic [pmtx_pkg::ROM_DATA_W-1:0] rom_data;
	logic [7:0]                      station_addr_byte0;
	logic [7:0]                      station_addr_byte1;
	logic [7:0]                      station_addr_byte2;
	logic [7:0]                      station_addr_byte3;
	logic [7:0]                      station_addr_byte4;
	logic [7:0]                      station_addr_byte5;
	logic                            tx_idle_irq_enable;
	logic                            four_led_mode_select;

	// Engine state
	pmtx_pkg::pmtx_fl_state_t fl_state;
	pmtx_pkg::pmtx_fl_state_t next_fl_state;
	logic [15:0]              fl_cnt;
	logic [7:0]               dq_meta;
	logic [7:0]               dq_sync;
	logic [4:0]               burst_seen;
	logic [11:0]              idle_timer;
	logic                     idle_armed;
	logic [11:0]              presc;

	// Supported power states: D0 and D3hot always, others by parameter
	function automatic logic ps_supported(input logic [1:0] ps);
		ps_supported = (ps == pmtx_pkg::PS_D0) || (ps == pmtx_pkg::PS_D3HOT)
			|| ((ps == pmtx_pkg::PS_D1) && SUPPORT_D1)
			|| ((ps == pmtx_pkg::PS_D2) && SUPPORT_D2);
	endfunction : ps_supported

	// Address decode; unaligned or unknown offsets answer with an error
	wire aligned   = (paddr[1:0] == 2'b00);
	wire hit_pm    = aligned && (paddr == ADDR_W'(pmtx_pkg::OFF_PM));
	wire hit_txbr  = aligned && (paddr == ADDR_W'(pmtx_pkg::OFF_TXBR));
	wire hit_rom   = aligned && (paddr == ADDR_W'(pmtx_pkg::OFF_ROM));
	wire hit_sa_lo = aligned && (paddr == ADDR_W'(pmtx_pkg::OFF_SA_LO));
	wire hit_sa_hi = aligned && (paddr == ADDR_W'(pmtx_pkg::OFF_SA_HI));
	wire hit_ctrl  = aligned && (paddr == ADDR_W'(pmtx_pkg::OFF_CTRL));
	wire hit_any   = hit_pm | hit_txbr | hit_rom | hit_sa_lo | hit_sa_hi | hit_ctrl;
	wire access    = psel && penable;
	wire wr        = access && pwrite;
	wire fl_busy   = (fl_state != pmtx_pkg::FL_IDLE);

	// Zero wait states; error only on unmapped access
	assign pready  = 1'b1;
	assign pslverr = access && !hit_any;

	// Read words built from fields; reserved bits read zero
	wire [31:0] rd_pm = (32'(wake_event_flag) << pmtx_pkg::PM_WAKE_FLAG_BIT)
		| (32'(wake_signal_enable) << pmtx_pkg::PM_WAKE_EN_BIT)
		| (32'(power_state_field) << pmtx_pkg::PM_STATE_LSB);
	wire [31:0] rd_txbr = (32'(tx_burst_count) << pmtx_pkg::TXBR_CNT_LSB)
		| (32'(tx_idle_timeout) << pmtx_pkg::TXBR_TO_LSB);
	wire [31:0] rd_rom = (32'(rom_addr16_pin_select) << pmtx_pkg::ROM_SEL16_BIT)
		| (32'(rom_rd_req) << pmtx_pkg::ROM_RD_BIT)
		| (32'(rom_wr_req) << pmtx_pkg::ROM_WR_BIT)
		| (32'(rom_addr) << pmtx_pkg::ROM_ADDR_LSB)
		| (32'(rom_data) << pmtx_pkg::ROM_DATA_LSB);
	wire [31:0] rd_sa_lo = (32'(station_addr_byte3) << pmtx_pkg::SA_HI_BYTE_LSB)
		| (32'(station_addr_byte2) << pmtx_pkg::SA_MH_BYTE_LSB)
		| (32'(station_addr_byte1) << pmtx_pkg::SA_ML_BYTE_LSB)
		| (32'(station_addr_byte0) << pmtx_pkg::SA_LO_BYTE_LSB);
	wire [31:0] rd_sa_hi = (32'(station_addr_byte5) << pmtx_pkg::SA_ML_BYTE_LSB)
		| (32'(station_addr_byte4) << pmtx_pkg::SA_LO_BYTE_LSB);
	wire [31:0] rd_ctrl = (32'(tx_idle_irq_enable) << pmtx_pkg::CTRL_IDLE_EN_BIT)
		| (32'(four_led_mode_select) << pmtx_pkg::CTRL_FOUR_LED_BIT)
		| (32'(fl_busy) << pmtx_pkg::CTRL_BUSY_BIT)
		| (32'(link_speed_100) << pmtx_pkg::CTRL_SPEED_BIT);
	wire [31:0] rd_word = hit_pm ? rd_pm : hit_txbr ? rd_txbr : hit_rom ? rd_rom
		: hit_sa_lo ? rd_sa_lo : hit_sa_hi ? rd_sa_hi : hit_ctrl ? rd_ctrl : 32'h0000_0000;

	// Write field slices
	wire [1:0]  wr_ps     = pwdata[pmtx_pkg::PM_STATE_LSB +: pmtx_pkg::PM_STATE_W];
	wire [16:0] wr_raddr  = pwdata[pmtx_pkg::ROM_ADDR_LSB +: pmtx_pkg::ROM_ADDR_W];
	wire [7:0]  wr_rdata  = pwdata[pmtx_pkg::ROM_DATA_LSB +: pmtx_pkg::ROM_DATA_W];
	// ROM port fields other than the pin select are locked while an access runs
	wire        rom_wr_ok = wr && hit_rom && !fl_busy;
	wire        rd_done   = (fl_state == pmtx_pkg::FL_READ) && (fl_cnt == 16'(FL_RD_CYC - 1));
	wire        wr_done   = (fl_state == pmtx_pkg::FL_WRITE) && (fl_cnt == 16'(FL_WR_CYC - 1));

	// Read data sampled in the setup phase, presented in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= rd_word;
	end

	// Power management command/status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wake_signal_enable <= 1'b0;
			wake_event_flag    <= 1'b0;
			power_state_field  <= pmtx_pkg::PS_D0;
		end
		else
		begin
			if (wr && hit_pm)
				wake_signal_enable <= pwdata[pmtx_pkg::PM_WAKE_EN_BIT];
			if (wake_event)
				wake_event_flag <= 1'b1;
			else if (wr && hit_pm && pwdata[pmtx_pkg::PM_WAKE_FLAG_BIT])
				wake_event_flag <= 1'b0;
			if (wr && hit_pm && ps_supported(wr_ps))
				power_state_field <= pmtx_pkg::pmtx_pstate_t'(wr_ps);
		end
	end

	// Wake output is open-drain, pulled low only when enabled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pme_oe <= 1'b0;
		else
			pme_oe <= wake_event_flag && wake_signal_enable;
	end
	assign pme_out     = 1'b0;
	assign power_state = power_state_field;

	// Transmit burst / timeout and local control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_burst_count       <= '0;
			tx_idle_timeout      <= '0;
			tx_idle_irq_enable   <= 1'b0;
			four_led_mode_select <= 1'b0;
		end
		else
		begin
			if (wr && hit_txbr)
			begin
				tx_burst_count  <= pwdata[pmtx_pkg::TXBR_CNT_LSB +: pmtx_pkg::TXBR_CNT_W];
				tx_idle_timeout <= pwdata[pmtx_pkg::TXBR_TO_LSB +: pmtx_pkg::TXBR_TO_W];
			end
			if (wr && hit_ctrl)
			begin
				tx_idle_irq_enable   <= pwdata[pmtx_pkg::CTRL_IDLE_EN_BIT];
				four_led_mode_select <= pwdata[pmtx_pkg::CTRL_FOUR_LED_BIT];
			end
		end
	end

	// Station address: EEPROM load takes precedence over a same-cycle bus write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			station_addr_byte0 <= 8'h00;
			station_addr_byte1 <= 8'h00;
			station_addr_byte2 <= 8'h00;
			station_addr_byte3 <= 8'h00;
			station_addr_byte4 <= 8'h00;
			station_addr_byte5 <= 8'h00;
		end
		else if (ee_load)
		begin
			{station_addr_byte5, station_addr_byte4} <= ee_station_addr[47:32];
			{station_addr_byte3, station_addr_byte2} <= ee_station_addr[31:16];
			{station_addr_byte1, station_addr_byte0} <= ee_station_addr[15:0];
		end
		else if (wr && hit_sa_lo)
		begin
			station_addr_byte3 <= pwdata[pmtx_pkg::SA_HI_BYTE_LSB +: pmtx_pkg::SA_BYTE_W];
			station_addr_byte2 <= pwdata[pmtx_pkg::SA_MH_BYTE_LSB +: pmtx_pkg::SA_BYTE_W];
			station_addr_byte1 <= pwdata[pmtx_pkg::SA_ML_BYTE_LSB +: pmtx_pkg::SA_BYTE_W];
			station_addr_byte0 <= pwdata[pmtx_pkg::SA_LO_BYTE_LSB +: pmtx_pkg::SA_BYTE_W];
		end
		else if (wr && hit_sa_hi)
		begin
			station_addr_byte5 <= pwdata[pmtx_pkg::SA_ML_BYTE_LSB +: pmtx_pkg::SA_BYTE_W];
			station_addr_byte4 <= pwdata[pmtx_pkg::SA_LO_BYTE_LSB +: pmtx_pkg::SA_BYTE_W];
		end
	end

	// Burst counter; a failed burst breaks the consecutive run
	wire [5:0] burst_next = {1'b0, burst_seen} + 6'h01;
	wire       burst_hit  = tx_burst_ok && (burst_next >= {1'b0, tx_burst_count});
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			burst_seen  <= 5'h00;
			tx_done_irq <= 1'b0;
		end
		else
		begin
			tx_done_irq <= burst_hit;
			if (tx_burst_fail || burst_hit)
				burst_seen <= 5'h00;
			else if (tx_burst_ok)
				burst_seen <= burst_next[4:0];
		end
	end

	// Prescaler picks its period from the link speed each tick
	wire [11:0] presc_lim = link_speed_100 ? 12'(pmtx_pkg::TICK_100_CYC - 1)
		: 12'(pmtx_pkg::TICK_10_CYC - 1);
	wire        run       = idle_armed && tx_idle_irq_enable;
	wire        tick      = run && (presc >= presc_lim);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			presc <= 12'h000;
		else if (!run || tick)
			presc <= 12'h000;
		else
			presc <= presc + 12'h001;
	end

	// Idle timer armed by each completed burst, disarmed by a new transmit
	wire expire = tick && (idle_timer <= 12'h001);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			idle_timer  <= 12'h000;
			idle_armed  <= 1'b0;
			tx_idle_irq <= 1'b0;
		end
		else
		begin
			tx_idle_irq <= expire && !tx_start;
			if (tx_start)
				idle_armed <= 1'b0;
			else if (tx_burst_ok)
			begin
				idle_timer <= tx_idle_timeout;
				idle_armed <= 1'b1;
			end
			else if (expire)
				idle_armed <= 1'b0;
			else if (tick)
				idle_timer <= idle_timer - 12'h001;
		end
	end

	// ROM port register; hardware completion clears the request bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rom_addr16_pin_select <= pmtx_pkg::ROM_SEL16_RST;
			rom_rd_req            <= 1'b0;
			rom_wr_req            <= 1'b0;
			rom_addr              <= '0;
			rom_data              <= '0;
		end
		else
		begin
			if (wr && hit_rom)
				rom_addr16_pin_select <= pwdata[pmtx_pkg::ROM_SEL16_BIT];
			if (rom_wr_ok)
			begin
				rom_addr   <= wr_raddr;
				rom_data   <= wr_rdata;
				rom_rd_req <= pwdata[pmtx_pkg::ROM_RD_BIT];
				rom_wr_req <= pwdata[pmtx_pkg::ROM_WR_BIT];
			end
			if (rd_done)
			begin
				rom_data   <= dq_sync;
				rom_rd_req <= 1'b0;
			end
			if (wr_done)
				rom_wr_req <= 1'b0;
		end
	end

	// Flash data input synchroniser
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dq_meta <= 8'h00;
			dq_sync <= 8'h00;
		end
		else
		begin
			dq_meta <= flash_dq_in;
			dq_sync <= dq_meta;
		end
	end

	// Flash access sequencer; a read wins when both requests are set
	always_comb
	begin
		next_fl_state = fl_state;
		unique case (fl_state)
			pmtx_pkg::FL_IDLE:
				if (rom_rd_req)
					next_fl_state = pmtx_pkg::FL_READ;
				else if (rom_wr_req)
					next_fl_state = pmtx_pkg::FL_WRITE;
			pmtx_pkg::FL_READ:
				if (rd_done)
					next_fl_state = pmtx_pkg::FL_RECOVER;
			pmtx_pkg::FL_WRITE:
				if (wr_done)
					next_fl_state = pmtx_pkg::FL_RECOVER;
			pmtx_pkg::FL_RECOVER:
				next_fl_state = pmtx_pkg::FL_IDLE;
		endcase
	end

	// Strobes registered so the pins never glitch on state decode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fl_state    <= pmtx_pkg::FL_IDLE;
			fl_cnt      <= 16'h0000;
			flash_ce_n  <= 1'b1;
			flash_oe_n  <= 1'b1;
			flash_we_n  <= 1'b1;
			flash_dq_oe <= 1'b0;
		end
		else
		begin
			fl_state    <= next_fl_state;
			fl_cnt      <= (next_fl_state == fl_state) ? fl_cnt + 16'h0001 : 16'h0000;
			flash_ce_n  <= !((next_fl_state == pmtx_pkg::FL_READ)
				|| (next_fl_state == pmtx_pkg::FL_WRITE));
			flash_oe_n  <= !(next_fl_state == pmtx_pkg::FL_READ);
			flash_we_n  <= !(next_fl_state == pmtx_pkg::FL_WRITE);
			// Data held one cycle past the write strobe for hold time
			flash_dq_oe <= (next_fl_state == pmtx_pkg::FL_WRITE)
				|| ((next_fl_state == pmtx_pkg::FL_RECOVER) && (fl_state == pmtx_pkg::FL_WRITE));
		end
	end
	assign flash_addr   = rom_addr;
	assign flash_dq_out = rom_data;

	// Shared pin: address line 16 only in four-LED mode with select set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			shared_led_pin <= 1'b0;
		else
			shared_led_pin <= (four_led_mode_select && rom_addr16_pin_select)
				? rom_addr[pmtx_pkg::ROM_ADDR_W-1] : led_fd_col;
	end

endmodule : pmtx_csrs

// [logic/pmtx_pkg.sv]
package pmtx_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_PM    = 8'h90;
	localparam logic [7:0] OFF_TXBR  = 8'h9c;
	localparam logic [7:0] OFF_ROM   = 8'ha0;
	localparam logic [7:0] OFF_SA_LO = 8'ha4;
	localparam logic [7:0] OFF_SA_HI = 8'ha8;
	localparam logic [7:0] OFF_CTRL  = 8'hb0;

	// Power-management command/status fields
	localparam int PM_WAKE_FLAG_BIT = 15;
	localparam int PM_WAKE_EN_BIT   = 8;
	localparam int PM_STATE_LSB     = 0;
	localparam int PM_STATE_W       = 2;

	// Transmit burst count / idle timeout fields
	localparam int TXBR_CNT_LSB = 16;
	localparam int TXBR_CNT_W   = 5;
	localparam int TXBR_TO_LSB  = 0;
	localparam int TXBR_TO_W    = 12;

	// Boot ROM port fields
	localparam int   ROM_SEL16_BIT  = 31;
	localparam int   ROM_RD_BIT     = 27;
	localparam int   ROM_WR_BIT     = 26;
	localparam int   ROM_ADDR_LSB   = 8;
	localparam int   ROM_ADDR_W     = 17;
	localparam int   ROM_DATA_LSB   = 0;
	localparam int   ROM_DATA_W     = 8;
	localparam logic ROM_SEL16_RST  = 1'b1;

	// Station address byte positions
	localparam int SA_HI_BYTE_LSB = 24;
	localparam int SA_MH_BYTE_LSB = 16;
	localparam int SA_ML_BYTE_LSB = 8;
	localparam int SA_LO_BYTE_LSB = 0;
	localparam int SA_BYTE_W      = 8;

	// Local control/status fields
	localparam int CTRL_IDLE_EN_BIT  = 0;
	localparam int CTRL_FOUR_LED_BIT = 1;
	localparam int CTRL_BUSY_BIT     = 8;
	localparam int CTRL_SPEED_BIT    = 9;

	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_100_NS   = 2560;
	localparam int TICK_10_NS    = 25600;
	localparam int TICK_100_CYC  = (TICK_100_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_10_CYC   = (TICK_10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_STAGES   = 2;

	typedef enum logic [1:0] {
		PS_D0    = 2'b00,
		PS_D1    = 2'b01,
		PS_D2    = 2'b10,
		PS_D3HOT = 2'b11
	} pmtx_pstate_t;

	typedef enum logic [1:0] {
		FL_IDLE    = 2'b00,
		FL_READ    = 2'b01,
		FL_WRITE   = 2'b10,
		FL_RECOVER = 2'b11
	} pmtx_fl_state_t;

endpackage : pmtx_pkg

// [sim/pmtx_flash_model.sv]
`timescale 1ns/10ps
// Byte-wide flash boot ROM as seen from its pins
module pmtx_flash_model (
	// Flash pins
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [16:0] addr,
	input  wire logic [7:0]  dq_in,
	output logic      [7:0]  dq_out
);
	logic [7:0] mem [0:255];
	logic [7:0] last = 8'h00;

	// Known contents so a stray read never returns unknowns
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5a;
	end

	// Level-sensitive write while both strobes are low
	always @(ce_n, we_n, addr, dq_in)
		if (!ce_n && !we_n)
			mem[addr[7:0]] = dq_in;

	// Released bus shows the inverse of the last value, never a stale copy
	always @*
		if (!ce_n && !oe_n)
		begin
			last = mem[addr[7:0]];
			dq_out = last;
		end
		else
			dq_out = ~last;
endmodule : pmtx_flash_model

// [sim/pmtx_properties.sv]
`timescale 1ns/10ps
// Pin-level relations of the register bank
module pmtx_props #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// APB
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// Events and status
	input wire logic              tx_burst_ok,
	input wire logic              tx_start,
	input wire logic              tx_done_irq,
	input wire logic              tx_idle_irq,
	input wire logic [1:0]        power_state,
	input wire logic              pme_out,
	input wire logic              pme_oe,
	// Flash pins
	input wire logic [16:0]       flash_addr,
	input wire logic              flash_ce_n,
	input wire logic              flash_oe_n,
	input wire logic              flash_we_n,
	input wire logic              flash_dq_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Access phase of a power-management write
	wire pm_wr = psel && penable && pwrite && paddr == ADDR_W'(pmtx_pkg::OFF_PM);

	a_pme_open_drain: assert property (pme_oe |-> !pme_out)
		else $error("wake pin driven high");
	a_pme_gated: assert property (pm_wr && !pwdata[pmtx_pkg::PM_WAKE_EN_BIT] |=> ##1 !pme_oe)
		else $error("wake pin driven while disabled");
	a_pstate_by_bus: assert property (!$stable(power_state) |-> $past(pm_wr))
		else $error("power state moved without a write");
	a_pm_write_ok: assert property (pm_wr |-> pready && !pslverr)
		else $error("power write not completed normally");
	a_done_cause: assert property (tx_done_irq |-> $past(tx_burst_ok))
		else $error("done pulse without a good burst");
	a_idle_pulse: assert property (tx_idle_irq |=> !tx_idle_irq)
		else $error("idle interrupt longer than a pulse");
	a_idle_no_start: assert property (tx_idle_irq |-> !$past(tx_start))
		else $error("idle interrupt after a transmit start");
	a_rd_strobes: assert property ($fell(flash_oe_n) |->
		!flash_ce_n && flash_we_n && !flash_dq_oe)
		else $error("bad strobes at read start");
	a_rd_window: assert property ($fell(flash_oe_n) |->
		!flash_oe_n[*3] ##[1:40] flash_oe_n)
		else $error("read window length wrong");
	a_wr_strobes: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
		else $error("bad strobes during write");
	a_wr_dq_hold: assert property ($rose(flash_we_n) |-> flash_dq_oe)
		else $error("data released with write strobe");
	a_addr_steady: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
		else $error("flash address moved mid access");

	c_read: cover property ($fell(flash_oe_n));
	c_write: cover property ($fell(flash_we_n));
	c_done: cover property (tx_done_irq);
	c_idle: cover property (tx_idle_irq);
endmodule : pmtx_props

bind pmtx_csrs pmtx_props #(.ADDR_W(ADDR_W)) u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .tx_burst_ok, .tx_start, .tx_done_irq,
	.tx_idle_irq,
	.power_state, .pme_out, .pme_oe, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n,
	.flash_dq_oe);

// [sim/testbench.sv]
`timescale 1ns/10ps
// Self-checking bench for the power, transmit and flash registers
module testbench;
	localparam logic [7:0] A_PM = pmtx_pkg::OFF_PM;
	localparam logic [7:0] A_TX = pmtx_pkg::OFF_TXBR;
	localparam logic [7:0] A_ROM = pmtx_pkg::OFF_ROM;
	localparam logic [7:0] A_CTL = pmtx_pkg::OFF_CTRL;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0, flash_dq_in, flash_dq_out;
	logic [31:0] pwdata = 0, prdata, rd, lfsr = 32'hc4e80c6c;
	logic        pready, pslverr, err, pme_out, pme_oe, tx_done_irq, tx_idle_irq;
	logic        wake_event = 0, link_speed_100 = 1, tx_burst_ok = 0, tx_burst_fail = 0;
	logic        tx_start = 0, ee_load = 0, led_fd_col = 1, shared_led_pin;
	logic        flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
	logic [1:0]  power_state;
	logic [16:0] flash_addr;
	logic [47:0] ee_station_addr = 0;
	int          failures = 0, checks_done = 0, done_n = 0, idle_n = 0;

	pmtx_csrs #(.FLASH_ACCESS_NS(16)) u_dut (.*);
	pmtx_flash_model u_rom (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
		.addr(flash_addr), .dq_in(flash_dq_out), .dq_out(flash_dq_in));

	// Clock and interrupt pulse counters
	always #4 pclk = ~pclk;
	always @(posedge pclk)
	begin
		if (tx_done_irq === 1'b1) done_n++;
		if (tx_idle_irq === 1'b1) idle_n++;
	end

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd

	// Unsupported middle states leave the old one
	function automatic logic [1:0] exp_ps(logic [1:0] o, logic [1:0] n);
		return (n == 2'b01 || n == 2'b10) ? o : n;
	endfunction : exp_ps

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic stop_test();
		$display("Counts: %0d checks, %0d failures", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge pclk);
		end
		if (n == 50) failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following call never reassigns psel in this step
		@(posedge pclk);
	endtask : apb

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rchk

	// Poll until both flash request bits have cleared
	task automatic poll();
		int n;
		n = 0;
		rd = 32'hffff_ffff;
		while (rd[27:26] !== 2'b00 && n < 100)
		begin
			apb(1'b0, A_ROM, 32'h0);
			n++;
		end
		chk("rom_req_clear", 0, rd[27:26]);
	endtask : poll

	task automatic pin_case(input logic [31:0] c, input logic [31:0] w, input logic e);
		apb(1'b1, A_CTL, c);
		apb(1'b1, A_ROM, w);
		repeat (2) @(posedge pclk);
		chk("led_pin", e, shared_led_pin);
	endtask : pin_case

	// Arm the idle timer and time the interrupt
	task automatic idle_wait(input int lo, input int hi);
		int n;
		n = 0;
		tx_burst_ok <= 1'b1;
		@(posedge pclk);
		tx_burst_ok <= 1'b0;
		while (tx_idle_irq !== 1'b1 && n < hi)
		begin
			@(posedge pclk);
			n++;
		end
		chk("idle_delay", 1, n > lo && n < hi);
	endtask : idle_wait

	// Watchdog well beyond the longest expected run
	initial
	begin
		#(60000 * 8);
		failures++;
		stop_test();
	end

	initial
	begin
		logic [1:0]  ps [6] = '{2'd3, 2'd1, 2'd2, 2'd0, 2'd3, 2'd0};
		logic [1:0]  bs [6] = '{2'd1, 2'd1, 2'd2, 2'd1, 2'd1, 2'd1};
		logic [31:0] a, d;
		logic [1:0]  x;
		logic [47:0] sa;
		x = 2'b00;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk("rom_rst", A_ROM, 32'h8000_0000);
		rchk("txbr_rst", A_TX, 0);
		rchk("pm_rst", A_PM, 0);
		$display("test reset done");
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, A_PM, {30'h0, ps[i]});
			x = exp_ps(x, ps[i]);
			rchk("pstate", A_PM, {30'h0, x});
			chk("pstate_pin", {30'h0, x}, {30'h0, power_state});
		end
		$display("test power state done");
		wake_event <= 1'b1;
		@(posedge pclk);
		wake_event <= 1'b0;
		rchk("wake_flag", A_PM, 32'h8000);
		chk("pme_off", 0, pme_oe);
		apb(1'b1, A_PM, 32'h100);
		rchk("flag_kept", A_PM, 32'h8100);
		chk("pme_on", 1, pme_oe);
		apb(1'b1, A_PM, 32'h0);
		rchk("wake_gate", A_PM, 32'h8000);
		chk("pme_gated", 0, pme_oe);
		apb(1'b1, A_PM, 32'h8100);
		rchk("flag_clear", A_PM, 32'h100);
		chk("pme_rel", 0, pme_oe);
		$display("test wake done");
		for (int i = 0; i < 4; i++)
		begin
			a = rnd();
			d = rnd();
			apb(1'b1, A_ROM, {7'b1000010, a[16:0], d[7:0]});
			poll();
			chk("rom_mem", d[7:0], u_rom.mem[a[7:0]]);
			apb(1'b1, A_ROM, {7'b1000100, a[16:0], ~d[7:0]});
			poll();
			rchk("rom_read", A_ROM, {7'b1000000, a[16:0], d[7:0]});
		end
		$display("test flash done");
		pin_case(2, 32'h8000_0000, 1'b0);
		pin_case(2, 32'h8100_0000, 1'b1);
		pin_case(2, 32'h0000_0000, 1'b1);
		led_fd_col <= 1'b0;
		pin_case(0, 32'h8100_0000, 1'b0);
		$display("test shared pin done");
		d = rnd() & 32'h001f_0fff;
		apb(1'b1, A_TX, d);
		rchk("txbr", A_TX, d);
		apb(1'b1, A_TX, 32'h0003_0002);
		for (int i = 0; i < 6; i++)
		begin
			tx_burst_ok <= bs[i][0];
			tx_burst_fail <= bs[i][1];
			@(posedge pclk);
			tx_burst_ok <= 1'b0;
			tx_burst_fail <= 1'b0;
			@(posedge pclk);
		end
		repeat (2) @(posedge pclk);
		chk("done_count", 1, done_n);
		$display("test burst done");
		apb(1'b1, A_CTL, 1);
		rchk("ctrl_rd", A_CTL, 32'h0000_0201);
		idle_wait(320, 645);
		tx_burst_ok <= 1'b1;
		@(posedge pclk);
		tx_burst_ok <= 1'b0;
		tx_start <= 1'b1;
		@(posedge pclk);
		tx_start <= 1'b0;
		repeat (800) @(posedge pclk);
		chk("idle_count", 1, idle_n);
		link_speed_100 <= 1'b0;
		idle_wait(3200, 6405);
		$display("test idle timer done");
		d = rnd();
		sa = {d[15:0], rnd()};
		ee_station_addr <= sa;
		ee_load <= 1'b1;
		@(posedge pclk);
		ee_load <= 1'b0;
		rchk("sa_low", pmtx_pkg::OFF_SA_LO, sa[31:0]);
		rchk("sa_high", pmtx_pkg::OFF_SA_HI, {16'h0, sa[47:32]});
		d = rnd();
		apb(1'b1, pmtx_pkg::OFF_SA_LO, d);
		rchk("sa_write", pmtx_pkg::OFF_SA_LO, d);
		apb(1'b1, 8'hfc, rnd());
		chk("slverr", 1, err);
		rchk("unmapped", 8'hfc, 0);
		$display("test station and map done");
		stop_test();
	end
endmodule : testbench
